// ### include/sleep_trim_pkg.sv
// Purpose: Constants and types for the sleep mask, delay trim and
//          input pattern checker register slice.
// Assumes: 32-bit Avalon-MM data, word-aligned byte addresses.
// Notes:   Byte address of a register is four times its index.
package sleep_trim_pkg;
    localparam int DATA_W = 16;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam int POS_W = 3;
    localparam int PATTERN_DEPTH = 8;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_SLEEP_MASK = 6'h23;
    localparam logic [IDX_W-1:0] IDX_DELAY_TRIM = 6'h24;
    localparam logic [IDX_W-1:0] IDX_WORD_ZERO = 6'h25;
    localparam logic [IDX_W-1:0] IDX_WORD_LAST = 6'h2C;
    localparam logic [IDX_W-1:0] IDX_SERIAL_SLEEP = 6'h3D;
    localparam logic [IDX_W-1:0] IDX_CHECK_CTRL = 6'h3E;

    // Reset values
    localparam logic [DATA_W-1:0] RST_SLEEP_MASK = 16'hFFFF;
    localparam logic [DATA_W-1:0] RST_SERIAL_SLEEP = 16'h0000;
    localparam logic [2:0] RST_DELAY = 3'h0;
    localparam logic [PATTERN_DEPTH-1:0][DATA_W-1:0] RST_WORDS = {
        16'hC6C6, 16'hAAAA, 16'h1616, 16'h1A1A,
        16'h4545, 16'hEAEA, 16'hB6B6, 16'h7A7A};

    // Sleep mask bit positions
    localparam int SLEEP_IN_PHASE = 14;
    localparam int SLEEP_QUADRATURE = 13;
    localparam int SLEEP_CLOCK_RX = 11;
    localparam int SLEEP_PLL = 10;
    localparam int SLEEP_DATA_RX = 9;
    localparam int SLEEP_CONTROL_RX = 8;
    localparam int SLEEP_TEMP_SENSOR = 7;
    localparam int SLEEP_BIAS_AMP = 5;
    localparam logic [DATA_W-1:0] SLEEP_USED = 16'h6FA0;

    // Delay trim fields, step of roughly 50 ps per count
    localparam int DATA_DLY_HI = 15;
    localparam int DATA_DLY_LO = 13;
    localparam int CLK_DLY_HI = 12;
    localparam int CLK_DLY_LO = 10;
    localparam int DELAY_STEP_PS = 50;

    // Check control bits
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_MISMATCH = 1;
    localparam int CTRL_SYNCED = 2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_FETCH = 2'b01,
        BUS_DONE = 2'b10
    } bus_phase_type;
endpackage

// ### include/pattern_mem_if.sv
// Purpose: Carrier between the register slice and its pattern memory.
// Assumes: One write port, two registered read ports.
// Notes:   ctrl drives addresses, mem returns registered data.
`timescale 1ns/100ps
interface pattern_mem_if;
    logic we;
    logic [2:0] waddr;
    logic [15:0] wdata;
    logic [1:0] wbe;
    logic [2:0] bus_raddr;
    logic [15:0] bus_rdata;
    logic [2:0] chk_raddr;
    logic [15:0] chk_rdata;
    modport ctrl (output we, waddr, wdata, wbe, bus_raddr, chk_raddr,
                  input bus_rdata, chk_rdata);
    modport mem (input we, waddr, wdata, wbe, bus_raddr, chk_raddr,
                 output bus_rdata, chk_rdata);
endinterface

// ### src/pattern_mem.sv
// Purpose: Eight-word expected input pattern with registered reads.
// Assumes: Byte enables act on the two lanes of a word.
// Notes:   Words reset to their default pattern values.
`timescale 1ns/100ps
module pattern_mem
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Access port
    pattern_mem_if.mem port
);
    import sleep_trim_pkg::*;

    typedef struct packed {
        logic [PATTERN_DEPTH-1:0][DATA_W-1:0] words;
        logic [DATA_W-1:0] bus_q;
        logic [DATA_W-1:0] chk_q;
    } mem_state_type;

    mem_state_type st_reg;
    mem_state_type st_next;

    always_comb
    begin
        st_next = st_reg;
        if (port.we)
        begin
            if (port.wbe[0])
                st_next.words[port.waddr][7:0] = port.wdata[7:0];
            if (port.wbe[1])
                st_next.words[port.waddr][15:8] = port.wdata[15:8];
        end
        st_next.bus_q = st_reg.words[port.bus_raddr];
        st_next.chk_q = st_reg.words[port.chk_raddr];
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_reg <= '{words: RST_WORDS, bus_q: '0, chk_q: '0};
        else
            st_reg <= st_next;
    end

    assign port.bus_rdata = st_reg.bus_q;
    assign port.chk_rdata = st_reg.chk_q;
endmodule // pattern_mem

// ### src/sleep_trim_regs.sv
// Purpose: Sleep pin mask, receiver delay trim and input pattern check.
// Assumes: Avalon-MM slave, word-aligned byte addresses, inputs are
//          synchronous to clock_i.
// Notes:   Rules of operation follow.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
module sleep_trim_regs
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Avalon-MM slave
    input wire logic [sleep_trim_pkg::ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [sleep_trim_pkg::BUS_W-1:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [sleep_trim_pkg::BUS_W-1:0] readdata_o,
    output logic waitrequest_o,
    // Sleep pin and block sleep controls
    input wire logic sleep_pin_i,
    output logic [sleep_trim_pkg::DATA_W-1:0] block_sleep_o,
    // Receiver delay trims
    output logic [2:0] data_delay_o,
    output logic [2:0] clock_delay_o,
    // Received input data and pattern check result
    input wire logic [sleep_trim_pkg::DATA_W-1:0] rx_word_i,
    input wire logic rx_valid_i,
    input wire logic frame_i,
    output logic check_mismatch_o
);
    import sleep_trim_pkg::*;

    typedef struct packed {
        bus_phase_type phase;
        logic [BUS_W-1:0] readdata;
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] serial_sleep;
        logic [2:0] data_dly;
        logic [2:0] clk_dly;
        logic [DATA_W-1:0] sleep_out;
        logic chk_en;
        logic mismatch;
        logic synced;
        logic frame_prev;
        logic [POS_W-1:0] pos;
        logic cmp_valid;
        logic [DATA_W-1:0] cmp_word;
    } state_type;

    state_type st_reg;
    state_type st_next;
    pattern_mem_if mem_port ();

    logic [IDX_W-1:0] index;
    logic request;
    logic done;
    logic frame_rise;
    logic [POS_W-1:0] pos_now;
    logic clear_mismatch;

    function automatic logic in_pattern(input logic [IDX_W-1:0] idx);
        return (idx >= IDX_WORD_ZERO) && (idx <= IDX_WORD_LAST);
    endfunction

    function automatic logic [POS_W-1:0] slot(input logic [IDX_W-1:0] idx);
        logic [IDX_W-1:0] d;
        d = idx - IDX_WORD_ZERO;
        return d[POS_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [1:0] be);
        logic [DATA_W-1:0] r;
        r = old_v;
        if (be[0])
            r[7:0] = new_v[7:0];
        if (be[1])
            r[15:8] = new_v[15:8];
        return r;
    endfunction

    assign index = address_i[ADDR_W-1:2];
    assign request = read_i | write_i;
    assign done = request && (st_reg.phase == BUS_DONE);
    assign waitrequest_o = request && (st_reg.phase != BUS_DONE);
    assign frame_rise = frame_i && !st_reg.frame_prev;
    assign pos_now = frame_rise ? '0 : POS_W'(st_reg.pos + 1'b1);
    assign clear_mismatch = done && write_i && (index == IDX_CHECK_CTRL)
        && byteenable_i[0] && writedata_i[CTRL_MISMATCH];

    // Pattern memory ports
    assign mem_port.we = done && write_i && in_pattern(index);
    assign mem_port.waddr = slot(index);
    assign mem_port.wdata = writedata_i[DATA_W-1:0];
    assign mem_port.wbe = byteenable_i[1:0];
    assign mem_port.bus_raddr = slot(index);
    assign mem_port.chk_raddr = pos_now;

    pattern_mem u_mem
    (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .port(mem_port.mem)
    );

    always_comb
    begin
        logic [DATA_W-1:0] rd;
        logic [DATA_W-1:0] trim;
        rd = '0;
        trim = '0;
        st_next = st_reg;

        // Bus phases: address, fetch, answer
        case (st_reg.phase)
            BUS_IDLE:
                if (request)
                    st_next.phase = BUS_FETCH;
            BUS_FETCH:
            begin
                trim[DATA_DLY_HI:DATA_DLY_LO] = st_reg.data_dly;
                trim[CLK_DLY_HI:CLK_DLY_LO] = st_reg.clk_dly;
                if (in_pattern(index))
                    rd = mem_port.bus_rdata;
                else if (index == IDX_SLEEP_MASK)
                    rd = st_reg.mask;
                else if (index == IDX_DELAY_TRIM)
                    rd = trim;
                else if (index == IDX_SERIAL_SLEEP)
                    rd = st_reg.serial_sleep;
                else if (index == IDX_CHECK_CTRL)
                begin
                    rd[CTRL_ENABLE] = st_reg.chk_en;
                    rd[CTRL_MISMATCH] = st_reg.mismatch;
                    rd[CTRL_SYNCED] = st_reg.synced;
                end
                st_next.readdata = {{(BUS_W-DATA_W){1'b0}}, rd};
                st_next.phase = request ? BUS_DONE : BUS_IDLE;
            end
            BUS_DONE:
                st_next.phase = BUS_IDLE;
            default:
                st_next.phase = BUS_IDLE;
        endcase

        // Register writes take effect on the answering edge
        if (done && write_i)
        begin
            if (index == IDX_SLEEP_MASK)
                st_next.mask = merge(st_reg.mask, writedata_i[DATA_W-1:0],
                    byteenable_i[1:0]);
            if (index == IDX_SERIAL_SLEEP)
                st_next.serial_sleep = merge(st_reg.serial_sleep,
                    writedata_i[DATA_W-1:0], byteenable_i[1:0]);
            if (index == IDX_DELAY_TRIM && byteenable_i[1])
            begin
                st_next.data_dly = writedata_i[DATA_DLY_HI:DATA_DLY_LO];
                st_next.clk_dly = writedata_i[CLK_DLY_HI:CLK_DLY_LO];
            end
            if (index == IDX_CHECK_CTRL && byteenable_i[0])
                st_next.chk_en = writedata_i[CTRL_ENABLE];
        end

        // Pin path gated by mask, used serial bits always kept
        st_next.sleep_out = ((st_reg.mask & {DATA_W{sleep_pin_i}})
            | st_reg.serial_sleep) & SLEEP_USED;

        // Sequence position follows the frame marker
        st_next.frame_prev = frame_i;
        st_next.cmp_valid = 1'b0;
        if (rx_valid_i)
        begin
            st_next.pos = pos_now;
            if (frame_rise)
                st_next.synced = 1'b1;
            st_next.cmp_valid = st_reg.chk_en && (frame_rise || st_reg.synced);
            st_next.cmp_word = rx_word_i;
        end
        if (!st_reg.chk_en)
            st_next.synced = 1'b0;

        // Sticky mismatch, a new mismatch beats the clear
        if (clear_mismatch)
            st_next.mismatch = 1'b0;
        if (st_reg.cmp_valid && (st_reg.cmp_word != mem_port.chk_rdata))
            st_next.mismatch = 1'b1;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_reg <= '{phase: BUS_IDLE, readdata: '0,
                mask: RST_SLEEP_MASK, serial_sleep: RST_SERIAL_SLEEP,
                data_dly: RST_DELAY, clk_dly: RST_DELAY, sleep_out: '0,
                chk_en: 1'b0, mismatch: 1'b0, synced: 1'b0,
                frame_prev: 1'b0, pos: '0, cmp_valid: 1'b0, cmp_word: '0};
        else
            st_reg <= st_next;
    end

    assign readdata_o = st_reg.readdata;
    assign block_sleep_o = st_reg.sleep_out;
    assign data_delay_o = st_reg.data_dly;
    assign clock_delay_o = st_reg.clk_dly;
    assign check_mismatch_o = st_reg.mismatch;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    pin_path_on_a: assert property (
        sleep_pin_i && st_reg.mask[SLEEP_IN_PHASE]
        |=> block_sleep_o[SLEEP_IN_PHASE])
        else $error("masked pin did not sleep in-phase converter");
    pin_path_off_a: assert property (
        !sleep_pin_i && !st_reg.serial_sleep[SLEEP_QUADRATURE]
        |=> !block_sleep_o[SLEEP_QUADRATURE])
        else $error("quadrature converter slept without cause");
    bias_cause_a: assert property (
        block_sleep_o[SLEEP_BIAS_AMP]
        |-> $past(st_reg.serial_sleep[SLEEP_BIAS_AMP])
        || ($past(sleep_pin_i) && $past(st_reg.mask[SLEEP_BIAS_AMP])))
        else $error("bias amplifier sleep without cause");
    serial_kept_a: assert property (
        st_reg.serial_sleep[SLEEP_QUADRATURE]
        && !st_reg.mask[SLEEP_QUADRATURE]
        |=> block_sleep_o[SLEEP_QUADRATURE])
        else $error("serial sleep cancelled by mask");
    data_delay_a: assert property (
        done && write_i && index == IDX_DELAY_TRIM && byteenable_i[1]
        |=> data_delay_o == $past(writedata_i[DATA_DLY_HI:DATA_DLY_LO]))
        else $error("data delay not updated");
    clock_delay_a: assert property (
        done && write_i && index == IDX_DELAY_TRIM && byteenable_i[1]
        |=> clock_delay_o == $past(writedata_i[CLK_DLY_HI:CLK_DLY_LO]))
        else $error("clock delay not updated");
    frame_align_a: assert property (
        rx_valid_i && frame_rise && st_reg.chk_en
        |=> st_reg.cmp_valid && st_reg.pos == 3'h0)
        else $error("frame rise did not restart at word zero");
    mismatch_set_a: assert property (
        st_reg.cmp_valid && st_reg.cmp_word != mem_port.chk_rdata
        |=> check_mismatch_o
        ##1 (check_mismatch_o || $past(clear_mismatch)))
        else $error("mismatch not flagged");
    bus_answer_a: assert property (
        st_reg.phase == BUS_IDLE && read_i
        |-> waitrequest_o ##1 waitrequest_o ##1 !waitrequest_o)
        else $error("read answer not on third cycle");
endmodule // sleep_trim_regs

// ### tb/pattern_source.sv
// Purpose: Parallel data source sending the eight-word input pattern.
// Assumes: Pattern words 1 to 7 keep their reset values.
// Notes:   bad_i picks one word to corrupt; 8 corrupts none.
`timescale 1ns/100ps
module pattern_source
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Control from the bench
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic [3:0] bad_i,
    input wire logic [15:0] word0_i,
    // Data bus
    output logic [15:0] rx_word_o,
    output logic rx_valid_o,
    output logic frame_o
);
    import sleep_trim_pkg::*;
    logic [2:0] pos;
    logic run;
    logic gap;
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            {pos, run, gap, rx_valid_o, frame_o, rx_word_o} <= '0;
        end
        else if ((start_i || run) && !(slow_i && gap))
        begin
            // Word zero goes out with the frame rising
            rx_valid_o <= 1'b1;
            frame_o <= (pos == 3'h0);
            rx_word_o <= ((pos == 3'h0) ? word0_i : RST_WORDS[pos])
                ^ ((bad_i == {1'b0, pos}) ? 16'h0001 : 16'h0000);
            pos <= pos + 3'h1;
            run <= (pos != 3'h7);
            gap <= 1'b1;
        end
        else
        begin
            // Idle bus shows a changing pattern, not the last word
            rx_valid_o <= 1'b0;
            frame_o <= 1'b0;
            rx_word_o <= ~rx_word_o;
            gap <= 1'b0;
        end
    end
endmodule // pattern_source

// ### tb/testbench.sv
// Purpose: Self-checking bench for the sleep and trim register slice.
// Assumes: Byte address is four times the register index.
// Notes:   Register rows first, then trim, sleep and pattern cases.
`timescale 1ns/100ps
module testbench;
    import sleep_trim_pkg::*;
    typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;}
        row_type;
    logic clock_i, rstn_i, read_i, write_i, waitrequest_o, sleep_pin_i;
    logic rx_valid_i, frame_i, check_mismatch_o, start, slow;
    logic [7:0] address_i;
    logic [31:0] writedata_i, readdata_o, q;
    logic [3:0] byteenable_i, bad;
    logic [15:0] block_sleep_o, rx_word_i, word0;
    logic [2:0] data_delay_o, clock_delay_o;
    int fail_count, samples_checked;
    row_type rows[8] = '{'{1'b0, 8'h8C, 16'h0, 16'hFFFF},
        '{1'b0, 8'h90, 16'h0, 16'h0}, '{1'b0, 8'h94, 16'h0, 16'h7A7A},
        '{1'b0, 8'hF4, 16'h0, 16'h0}, '{1'b0, 8'hF8, 16'h0, 16'h0},
        '{1'b1, 8'h90, 16'hFFFF, 16'hFC00},
        '{1'b1, 8'h00, 16'hABCD, 16'h0},
        '{1'b1, 8'h94, 16'h1357, 16'h1357}};

    sleep_trim_regs u_sleep_trim_regs (.clock_i, .rstn_i, .address_i,
        .read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o,
        .waitrequest_o, .sleep_pin_i, .block_sleep_o, .data_delay_o,
        .clock_delay_o, .rx_word_i, .rx_valid_i, .frame_i,
        .check_mismatch_o);
    pattern_source u_pattern_source (.clock_i, .rstn_i, .start_i(start),
        .slow_i(slow), .bad_i(bad), .word0_i(word0), .rx_word_o(rx_word_i),
        .rx_valid_o(rx_valid_i), .frame_o(frame_i));

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", samples_checked,
            fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string s, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] be,
        input logic [7:0] a, input logic [15:0] d);
        address_i <= a;
        byteenable_i <= be;
        writedata_i <= {16'h0000, d};
        write_i <= w;
        read_i <= !w;
        @(posedge clock_i);
        while (waitrequest_o !== 1'b0)
            @(posedge clock_i);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e,
        input string s);
        bus(1'b0, 4'hF, a, 16'h0);
        chk(s, e, q[15:0]);
        chk("read_upper", 16'h0, q[31:16]);
    endtask

    task automatic send(input logic [3:0] b, input logic s,
        input logic [15:0] w0);
        bad <= b;
        slow <= s;
        word0 <= w0;
        start <= 1'b1;
        @(posedge clock_i);
        start <= 1'b0;
        repeat (30) @(posedge clock_i);
    endtask

    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    initial
    begin
        repeat (3000) @(posedge clock_i);
        fail_count++;
        test_done();
    end

    initial
    begin
        {rstn_i, read_i, write_i, sleep_pin_i, start, slow} = '0;
        {address_i, writedata_i, byteenable_i, bad, word0} = '0;
        repeat (16) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        foreach (rows[i])
        begin
            if (rows[i].w)
                bus(1'b1, 4'hF, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e, "register");
        end
        bus(1'b1, 4'hF, 8'h90, 16'hA400);
        repeat (2) @(posedge clock_i);
        chk("data_delay", 16'h5, {13'h0, data_delay_o});
        chk("clock_delay", 16'h1, {13'h0, clock_delay_o});
        bus(1'b1, 4'h1, 8'h90, 16'h0000);
        repeat (2) @(posedge clock_i);
        chk("delay_lane", 16'h5, {13'h0, data_delay_o});
        for (int i = 0; i < 16; i++)
        begin
            bus(1'b1, 4'hF, 8'h8C, 16'h0001 << i);
            sleep_pin_i <= 1'b1;
            repeat (3) @(posedge clock_i);
            chk("sleep_on", (16'h1 << i) & 16'h6FA0, block_sleep_o);
            sleep_pin_i <= 1'b0;
            repeat (3) @(posedge clock_i);
            chk("sleep_off", 16'h0, block_sleep_o);
        end
        bus(1'b1, 4'hF, 8'hF4, 16'h2020);
        bus(1'b1, 4'hF, 8'h8C, 16'h0000);
        sleep_pin_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("serial_sleep", 16'h2020, block_sleep_o);
        bus(1'b1, 4'hF, 8'h8C, 16'hFFFF);
        repeat (2) @(posedge clock_i);
        chk("both_sleep", 16'h6FA0, block_sleep_o);
        sleep_pin_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk("serial_kept", 16'h2020, block_sleep_o);
        bus(1'b1, 4'hF, 8'hF8, 16'h0001);
        send(4'h8, 1'b0, 16'h1357);
        chk("clean_run", 16'h0, {15'h0, check_mismatch_o});
        send(4'h5, 1'b1, 16'h1357);
        chk("bad_word", 16'h1, {15'h0, check_mismatch_o});
        rd(8'hF8, 16'h0007, "ctrl_flag");
        bus(1'b1, 4'hF, 8'hF8, 16'h0003);
        rd(8'hF8, 16'h0005, "ctrl_clear");
        chk("cleared", 16'h0, {15'h0, check_mismatch_o});
        send(4'h8, 1'b0, 16'h7A7A);
        chk("word_zero", 16'h1, {15'h0, check_mismatch_o});
        // Second reset in mid-run, with state other than the mask and pattern words 1 to 7 away from its reset values
        rstn_i <= 1'b0;
        sleep_pin_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("reset_sleep", 16'h0, block_sleep_o);
        chk("reset_flag", 16'h0, {15'h0, check_mismatch_o});
        chk("reset_data", 16'h0, {13'h0, data_delay_o});
        chk("reset_clock", 16'h0, {13'h0, clock_delay_o});
        rstn_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("reset_mask", 16'h6FA0, block_sleep_o);
        sleep_pin_i <= 1'b0;
        rd(8'hF4, 16'h0000, "reset_serial");
        rd(8'h94, 16'h7A7A, "reset_word");
        test_done();
    end
endmodule // testbench
